// >>> src/spfm_serial_port.sv
// Purpose: Four-mode serial port with AXI4-Lite register access
// Assumes: Pins synchronous to ref_clk; timerOvf from outside
// Notes:   rxd is two-way; txd is output only
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module spfm_serial_port
    import spfm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        timerOvf,
    input  wire logic        rxdIn,
    output logic             rxdOut,
    output logic             rxdOe,
    output logic             txdOut,
    output logic             txActive,
    output logic             rxActive
);
    typedef struct packed {
        spfm_tx_t    tx;
        spfm_rx_t    rx;
        logic [1:0]  mode;
        logic        mpf;
        logic        ren;
        logic        tx9;
        logic        rx9;
        logic        txf;
        logic        rxf;
        logic        dbl;
        logic        clk6;
        logic [8:0]  txSh;
        logic [8:0]  rxSh;
        logic [7:0]  rxBuf;
        logic        txFirst;
        logic [3:0]  txDiv;
        logic [3:0]  rxDiv;
        logic        rxPrev;
        logic        m0Samp;
        logic        txdOut;
        logic        rxdOut;
        logic        rxdOe;
        logic        awHave;
        logic        awOk;
        logic [3:0]  awAddr;
        logic        wHave;
        logic [7:0]  wByte;
        logic [3:0]  wStrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } spfm_state_t;

    spfm_state_t q;
    spfm_state_t d;
    logic        phTick;
    logic [3:0]  phase;
    logic [3:0]  phNext;
    logic        bdTick;
    logic        voteBit;
    logic        isM0;
    logic        evS1P1;
    logic        evS5P2;
    logic        evS6P2;
    logic        txRoll;
    logic        bitDone;
    logic        edgeSeen;
    logic        doWr;
    logic        wrLow;

    // ------------------------------------------------------------
    // Timing sources
    // ------------------------------------------------------------
    spfm_rate_gen u_rate (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .clk6Mode   (q.clk6),
        .baudDouble (q.dbl),
        .mode       (q.mode),
        .timerOvf   (timerOvf),
        .phaseTick  (phTick),
        .phase      (phase),
        .phaseNext  (phNext),
        .baudTick   (bdTick)
    );

    spfm_bit_vote u_vote (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .baudTick (bdTick),
        .divCount (q.rxDiv),
        .rxdIn    (rxdIn),
        .voteBit  (voteBit)
    );

    assign isM0     = (q.mode == MODE_SHIFT);
    assign evS1P1   = phTick && phase == PH_S1P1;
    assign evS5P2   = phTick && phase == PH_S5P2;
    assign evS6P2   = phTick && phase == PH_S6P2;
    assign txRoll   = bdTick && q.txDiv == DIV_LAST;
    assign bitDone  = bdTick && q.rxDiv == VOTE_C;
    assign edgeSeen = bdTick && q.rxPrev && !rxdIn;
    assign doWr     = q.awHave && q.wHave;
    assign wrLow    = doWr && q.awOk && q.wStrb[0];

    // ------------------------------------------------------------
    // Bus handshake and pin outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !q.awHave && !q.bvalid;
    assign s_axi_wready  = !q.wHave && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign txdOut        = q.txdOut;
    assign rxdOut        = q.rxdOut;
    assign rxdOe         = q.rxdOe;
    assign txActive      = q.tx == TX_START || q.tx == TX_SHIFT
                           || q.tx == TX_FIN;
    assign rxActive      = !(q.rx == RX_IDLE || q.rx == RX_M0ARM);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        txSet;
        logic        rxSet;
        logic        clrT;
        logic        clrR;
        logic        m0TxOn;
        logic        m0RxOn;
        logic        shClk;
        logic        rdOk;
        logic [31:0] rd;
        d      = q;
        txSet  = 1'b0;
        rxSet  = 1'b0;
        clrT   = 1'b0;
        clrR   = 1'b0;
        m0TxOn = 1'b0;
        m0RxOn = 1'b0;
        shClk  = 1'b1;
        rdOk   = 1'b0;
        rd     = 32'h0;

        // Write channels
        if (s_axi_awvalid && s_axi_awready) begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr[3:0];
            d.awOk   = s_axi_awaddr[31:4] == 28'h0
                       && s_axi_awaddr[1:0] == 2'b00;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wHave = 1'b1;
            d.wByte = s_axi_wdata[7:0];
            d.wStrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (doWr) begin
            d.awHave = 1'b0;
            d.wHave  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = q.awOk ? RESP_OKAY : RESP_SLVERR;
        end

        // Async dividers and edge sampler
        if (bdTick) begin
            d.txDiv  = q.txDiv + 4'h1;
            d.rxDiv  = q.rxDiv + 4'h1;
            d.rxPrev = rxdIn;
        end

        // Transmitter
        unique case (q.tx)
            TX_IDLE: begin
            end
            TX_REQ: begin
                if (isM0 ? evS6P2 : txRoll) begin
                    d.tx = TX_GO;
                end
            end
            TX_GO: begin
                if (isM0 && evS6P2) begin
                    d.tx = TX_SHIFT;
                end else if (!isM0 && evS1P1) begin
                    d.tx     = TX_START;
                    d.txdOut = 1'b0;
                end
            end
            TX_START: begin
                if (txRoll) begin
                    d.tx     = TX_SHIFT;
                    d.txdOut = q.txSh[0];
                end
            end
            TX_SHIFT: begin
                if (isM0 && evS6P2) begin
                    d.txSh = {1'b0, q.txSh[8:1]};
                    if (q.txSh[8:1] == TX_DONE_PAT) begin
                        d.tx = TX_FIN;
                    end
                end else if (!isM0 && txRoll) begin
                    d.txSh    = {q.mode[1] && q.txFirst, q.txSh[8:1]};
                    d.txFirst = 1'b0;
                    d.txdOut  = q.txSh[1];
                    if (q.txSh[8:1] == TX_DONE_PAT
                        && !(q.mode[1] && q.txFirst)) begin
                        d.tx  = TX_IDLE;
                        txSet = 1'b1;
                    end
                end
            end
            TX_FIN: begin
                if (evS1P1) begin
                    d.tx  = TX_IDLE;
                    txSet = 1'b1;
                end
            end
        endcase

        // Receiver
        unique case (q.rx)
            RX_IDLE: begin
                if (isM0 && q.ren && !q.rxf) begin
                    d.rx = RX_M0ARM;
                end else if (!isM0 && q.ren && edgeSeen) begin
                    d.rx    = RX_START;
                    d.rxDiv = 4'h0;
                    d.rxSh  = ASY_RX_LOAD;
                end
            end
            RX_M0ARM: begin
                if (evS6P2) begin
                    d.rxSh = {1'b0, M0_RX_LOAD};
                    d.rx   = RX_M0RUN;
                end
            end
            RX_M0RUN: begin
                if (evS5P2) begin
                    d.m0Samp = rxdIn;
                end
                if (evS6P2) begin
                    d.rxSh[7:0] = {q.m0Samp, q.rxSh[7:1]};
                    if (!q.rxSh[0]) begin
                        d.rx    = RX_M0FIN;
                        d.rxBuf = {q.m0Samp, q.rxSh[7:1]};
                    end
                end
            end
            RX_M0FIN: begin
                if (evS1P1) begin
                    d.rx  = RX_IDLE;
                    rxSet = 1'b1;
                end
            end
            RX_START: begin
                if (bitDone) begin
                    if (voteBit) begin
                        d.rx = RX_IDLE;
                    end else begin
                        d.rxSh = {1'b0, q.rxSh[8:1]};
                        d.rx   = RX_BITS;
                    end
                end
            end
            RX_BITS: begin
                if (bitDone && q.rxSh[0]) begin
                    d.rxSh = {voteBit, q.rxSh[8:1]};
                end else if (bitDone) begin
                    if (!q.rxf && (!q.mpf || voteBit)) begin
                        d.rxBuf = q.rxSh[8:1];
                        d.rx9   = voteBit;
                        rxSet   = 1'b1;
                    end
                    d.rx = (q.mode == MODE_ASY8) ? RX_IDLE : RX_HOLD;
                end
            end
            RX_HOLD: begin
                if (bitDone) begin
                    d.rx = RX_IDLE;
                end
            end
        endcase

        // Register writes
        if (wrLow && q.awAddr == OFS_DATA) begin
            d.txSh    = {q.mode[1] ? q.tx9 : 1'b1, q.wByte};
            d.tx      = TX_REQ;
            d.txFirst = 1'b1;
        end
        if (wrLow && q.awAddr == OFS_CTRL) begin
            d.mode = q.wByte[CTL_MODE +: 2];
            d.mpf  = q.wByte[CTL_MPF];
            d.ren  = q.wByte[CTL_REN];
            d.tx9  = q.wByte[CTL_TX9];
            if (!rxSet) begin
                d.rx9 = q.wByte[CTL_RX9];
            end
            clrT = !q.wByte[CTL_TXF];
            clrR = !q.wByte[CTL_RXF];
        end
        if (wrLow && q.awAddr == OFS_CFG) begin
            d.dbl  = q.wByte[CFG_DBL];
            d.clk6 = q.wByte[CFG_CLK6];
        end
        d.txf = (q.txf && !clrT) || txSet;
        d.rxf = (q.rxf && !clrR) || rxSet;

        // Register reads
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rdOk = s_axi_araddr[31:4] == 28'h0
                   && s_axi_araddr[1:0] == 2'b00;
            unique case (s_axi_araddr[3:2])
                2'd0: rd = {24'h0, q.rxBuf};
                2'd1: rd = {24'h0, q.mode, q.mpf, q.ren,
                            q.tx9, q.rx9, q.txf, q.rxf};
                2'd2: rd = {30'h0, q.clk6, q.dbl};
                2'd3: rd = {30'h0, rxActive, txActive};
            endcase
            d.rvalid = 1'b1;
            d.rdata  = rdOk ? rd : 32'h0;
            d.rresp  = rdOk ? RESP_OKAY : RESP_SLVERR;
        end

        // Pin drive
        m0TxOn = isM0 && (d.tx == TX_SHIFT || d.tx == TX_FIN);
        m0RxOn = isM0 && (d.rx == RX_M0RUN || d.rx == RX_M0FIN);
        shClk  = !(phNext >= PH_S3P1 && phNext <= PH_S5P2);
        if (isM0) begin
            d.txdOut = (m0TxOn || m0RxOn) ? shClk : 1'b1;
        end else if (d.tx == TX_IDLE || d.tx == TX_REQ || d.tx == TX_GO) begin
            d.txdOut = 1'b1;
        end
        d.rxdOe  = m0TxOn;
        d.rxdOut = m0TxOn ? d.txSh[0] : 1'b1;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q        <= '0;
            q.tx     <= TX_IDLE;
            q.rx     <= RX_IDLE;
            q.dbl    <= RST_DBL;
            q.clk6   <= RST_CLK6;
            q.txdOut <= 1'b1;
            q.rxdOut <= 1'b1;
            q.rxPrev <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule // spfm_serial_port

// >>> shared/spfm_pkg.sv
// Purpose: Shared constants and types of the four-mode serial port
// Assumes: ref_clk at 250 MHz is twice the oscillator rate
// Notes:   Register map, control fields, phase numbers, frame patterns
package spfm_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_DATA    = 4'h0;
    localparam logic [3:0] OFS_CTRL    = 4'h4;
    localparam logic [3:0] OFS_CFG     = 4'h8;
    localparam logic [3:0] OFS_STAT    = 4'hc;
    localparam int         CTL_RXF     = 0;
    localparam int         CTL_TXF     = 1;
    localparam int         CTL_RX9     = 2;
    localparam int         CTL_TX9     = 3;
    localparam int         CTL_REN     = 4;
    localparam int         CTL_MPF     = 5;
    localparam int         CTL_MODE    = 6;
    localparam int         CFG_DBL     = 0;
    localparam int         CFG_CLK6    = 1;
    localparam int         STAT_TXA    = 0;
    localparam int         STAT_RXA    = 1;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic       RST_DBL     = 1'b0;
    localparam logic       RST_CLK6    = 1'b0;

    // ------------------------------------------------------------
    // Timing and frame patterns
    // ------------------------------------------------------------
    localparam logic [3:0] PH_S1P1     = 4'h0;
    localparam logic [3:0] PH_S3P1     = 4'h4;
    localparam logic [3:0] PH_S5P2     = 4'h9;
    localparam logic [3:0] PH_S6P2     = 4'hb;
    localparam logic [3:0] DIV_LAST    = 4'hf;
    localparam logic [3:0] VOTE_A      = 4'h6;
    localparam logic [3:0] VOTE_B      = 4'h7;
    localparam logic [3:0] VOTE_C      = 4'h8;
    localparam logic [3:0] M2_BASE     = 4'h8;
    localparam logic [7:0] M0_RX_LOAD  = 8'h7f;
    localparam logic [8:0] ASY_RX_LOAD = 9'h1ff;
    localparam logic [7:0] TX_DONE_PAT = 8'h01;

    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_ASY8  = 2'b01,
        MODE_FIX9  = 2'b10,
        MODE_VAR9  = 2'b11
    } spfm_mode_t;

    typedef enum logic [5:0] {
        TX_IDLE  = 6'b000001,
        TX_REQ   = 6'b000010,
        TX_GO    = 6'b000100,
        TX_START = 6'b001000,
        TX_SHIFT = 6'b010000,
        TX_FIN   = 6'b100000
    } spfm_tx_t;

    typedef enum logic [6:0] {
        RX_IDLE  = 7'b0000001,
        RX_M0ARM = 7'b0000010,
        RX_M0RUN = 7'b0000100,
        RX_M0FIN = 7'b0001000,
        RX_START = 7'b0010000,
        RX_BITS  = 7'b0100000,
        RX_HOLD  = 7'b1000000
    } spfm_rx_t;

endpackage

// >>> src/spfm_rate_gen.sv
// Purpose: Machine-cycle phases and 16x baud tick
// Assumes: timerOvf is a one-cycle pulse per timer overflow
// Notes:   Oscillator taken as ref_clk / 2
`timescale 1ns/1ps
module spfm_rate_gen
    import spfm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       clk6Mode,
    input  wire logic       baudDouble,
    input  wire logic [1:0] mode,
    input  wire logic       timerOvf,
    output logic            phaseTick,
    output logic [3:0]      phase,
    output logic [3:0]      phaseNext,
    output logic            baudTick
);
    typedef struct packed {
        logic       pre;
        logic [3:0] phase;
        logic [3:0] m2Cnt;
        logic       ovfHalf;
        logic       dblPend;
        logic       tick;
    } spfm_rg_t;

    spfm_rg_t   q;
    spfm_rg_t   d;
    logic [1:0] expo;
    logic [3:0] m2Max;

    assign expo      = {1'b0, baudDouble} + {1'b0, clk6Mode};
    assign m2Max     = (M2_BASE >> expo) - 4'h1;
    assign phaseTick = clk6Mode | q.pre;
    assign phase     = q.phase;
    assign baudTick  = q.tick;

    // ------------------------------------------------------------
    // Phase and baud dividers
    // ------------------------------------------------------------
    always_comb begin
        d      = q;
        d.pre  = ~q.pre;
        d.tick = 1'b0;
        if (phaseTick) begin
            d.phase = (q.phase == PH_S6P2) ? PH_S1P1 : q.phase + 4'h1;
        end
        if (mode == MODE_FIX9) begin
            if (q.m2Cnt >= m2Max) begin
                d.m2Cnt = 4'h0;
                d.tick  = 1'b1;
            end else begin
                d.m2Cnt = q.m2Cnt + 4'h1;
            end
        end else if (timerOvf) begin
            unique case (expo)
                2'd0: begin
                    d.ovfHalf = ~q.ovfHalf;
                    d.tick    = q.ovfHalf;
                end
                2'd1: d.tick = 1'b1;
                default: begin
                    d.tick    = 1'b1;
                    d.dblPend = 1'b1;
                end
            endcase
        end else if (q.dblPend) begin
            d.tick    = 1'b1;
            d.dblPend = 1'b0;
        end
    end

    assign phaseNext = d.phase;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // spfm_rate_gen

// >>> src/spfm_bit_vote.sv
// Purpose: Two-of-three bit detector for asynchronous reception
// Assumes: divCount is the receive divide-by-16 count
// Notes:   Third sample is the live pin
`timescale 1ns/1ps
module spfm_bit_vote
    import spfm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       baudTick,
    input  wire logic [3:0] divCount,
    input  wire logic       rxdIn,
    output logic            voteBit
);
    typedef struct packed {
        logic s1;
        logic s2;
    } spfm_vote_t;

    spfm_vote_t q;
    spfm_vote_t d;

    always_comb begin
        d = q;
        if (baudTick && divCount == VOTE_A) begin
            d.s1 = rxdIn;
        end
        if (baudTick && divCount == VOTE_B) begin
            d.s2 = rxdIn;
        end
    end

    assign voteBit = (q.s1 & q.s2) | (q.s1 & rxdIn) | (q.s2 & rxdIn);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // spfm_bit_vote

// >>> dv/spfm_peer.sv
// Purpose: Remote peer, echoes each 11-bit frame
// Assumes: bitCycles is the ref_clk count per bit
// Notes:   rxd idles high, as with a pull-up
`timescale 1ns/1ps
module spfm_peer (
    input  wire logic        ref_clk,
    input  wire logic        en,
    input  wire logic [15:0] bitCycles,
    input  wire logic        txd,
    output logic             rxd,
    output logic             busy
);
    logic [10:0] frame;
    initial begin
        rxd = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (en && !txd) begin
                busy <= 1'b1;
                repeat (bitCycles / 2) @(posedge ref_clk);
                for (int i = 0; i < 11; i++) begin
                    frame[i] = txd;
                    repeat (bitCycles) @(posedge ref_clk);
                end
                for (int i = 0; i < 11; i++) begin
                    rxd <= frame[i];
                    repeat (bitCycles) @(posedge ref_clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // spfm_peer

// >>> dv/spfm_monitor.sv
// Purpose: Port checker of the serial port
// Assumes: Single clock domain
// Notes:   Bound to every spfm_serial_port
`timescale 1ns/1ps
module spfm_monitor (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        rxdOe,
    input wire logic        txdOut,
    input wire logic        txActive,
    input wire logic        rxActive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_ar_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("late read");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high");
    a_oe_send: assert property ($rose(rxdOe) |-> txActive)
        else $error("drive without send");
    a_idle_high: assert property (!txActive && !rxActive |-> txdOut)
        else $error("txd low idle");
    a_clk_low: assert property ($fell(txdOut) && rxdOe
        |-> (!txdOut)[*6]) else $error("short low");
    a_clk_high: assert property ($rose(txdOut) && rxdOe
        |-> txdOut[*6]) else $error("short high");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_tx_end: cover property ($fell(txActive));
    c_rx_end: cover property ($fell(rxActive));
endmodule // spfm_monitor
bind spfm_serial_port spfm_monitor u_mon (.ref_clk(ref_clk),
    .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .rxdOe(rxdOe), .txdOut(txdOut),
    .txActive(txActive), .rxActive(rxActive));

// >>> dv/tb.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Reads checked from a queue of notes
// Notes:   Mode 2 and mode 3 frames echoed by the peer
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
 failures++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
    import spfm_pkg::*;
    logic clk, rstN, awv, wv, bvalid, brdy, arv, rvalid, rrdy;
    logic awr, wr_, arr, rxdIn, rxdOut, rxdOe, txdOut, txA, rxA;
    logic peerRxd, peerEn, busy, ovf;
    logic [31:0] awaddr, wdata, araddr, rdata, seed;
    logic [1:0] rresp, bresp;
    logic [15:0] cyc;
    logic [33:0] expQ[$];
    logic [33:0] e;
    logic [7:0] b;
    logic n;
    int failures, total_checks;
    always #2 clk = ~clk;
    always @(posedge clk) ovf <= ~ovf;
    assign rxdIn = rxdOe ? rxdOut : peerRxd;
    spfm_serial_port DUT (.ref_clk(clk), .rst_n(rstN),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rrdy), .timerOvf(ovf),
        .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut),
        .txActive(txA), .rxActive(rxA));
    spfm_peer u_peer (.ref_clk(clk), .en(peerEn), .bitCycles(cyc),
        .txd(txdOut), .rxd(peerRxd), .busy(busy));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(logic [3:0] a, logic [7:0] d);
        awaddr <= {28'h0, a};
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do @(posedge clk); while (!(awr && wr_));
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge clk); while (!bvalid);
        brdy <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [33:0] x);
        expQ.push_back(x);
        araddr <= {24'h0, a};
        arv <= 1'b1;
        rrdy <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rrdy <= 1'b0;
    endtask
    task automatic settle();
        repeat (300) @(posedge clk);
        for (int i = 0; i < 20000 && (busy || txA || rxA); i++)
            @(posedge clk);
        if (busy || txA || rxA) failures++;
    endtask
    task automatic complete_run();
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (rvalid && rrdy && expQ.size() > 0) begin
            e = expQ.pop_front();
            `CHK("read", e, {rresp, rdata})
        end
        if (bvalid && brdy) begin
            `CHK("bresp", RESP_OKAY, bresp)
        end
    end
    initial begin
        #240000;
        failures++;
        complete_run();
    end
    initial begin
        {clk, rstN, awv, wv, brdy, arv, rrdy, peerEn, ovf} = 9'h000;
        {awaddr, wdata, araddr} = 96'h0;
        seed = 32'h9c07;
        cyc = 16'h80;
        repeat (12) @(posedge clk);
        rstN <= 1'b1;
        @(posedge clk);
        rd(OFS_CTRL, 34'h0);
        rd(OFS_CFG, 34'h0);
        rd(8'h10, {RESP_SLVERR, 32'h0});
        $display("Reset test done");
        wr(OFS_DATA, 8'h5a);
        settle();
        rd(OFS_CTRL, 34'h2);
        wr(OFS_CTRL, 8'h10);
        settle();
        rd(OFS_CTRL, 34'h11);
        rd(OFS_DATA, 34'hff);
        $display("Mode 0 test done");
        peerEn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            b = seed[7:0];
            n = seed[8];
            wr(OFS_CFG, 8'(k & 1));
            cyc <= (k != 0) ? 16'h40 : 16'h80;
            wr(OFS_CTRL, {1'b1, k == 2, 2'b01, n, 3'b000});
            wr(OFS_DATA, b);
            settle();
            rd(OFS_CTRL, {26'h0, 1'b1, k == 2, 2'b01, n, n, 2'b11});
            rd(OFS_DATA, {26'h0, b});
            $display("Async test %0d done", k);
        end
        wr(OFS_CTRL, 8'hf0);
        wr(OFS_DATA, ~b);
        settle();
        rd(OFS_CTRL, 34'hf2);
        rd(OFS_DATA, {26'h0, b});
        $display("Filter test done");
        complete_run();
    end
endmodule // tb
